// *** hdl/qbs_core.sv ***
/*
 Device-side burst-of-four protocol core: read and write sequencers, byte-lane
 write buffer with read bypass, and the storage array.
 Assumes selects and data are synchronous to core_clk_i; one core cycle carries
 a rise-phase and a fall-phase word.
*/
`timescale 1ns/100ps
`default_nettype none
module qbs_core import qbs_pkg::*; #(
    parameter int FIFO_DEPTH = QBS_FIFO_DEPTH,
    parameter int PEND_PAIRS = QBS_PEND_PAIRS
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Command
    input wire logic rd_sel_n_i,
    input wire logic wr_sel_n_i,
    input wire qbs_addr_t addr_i,
    // Write data
    input wire qbs_din_s din_i,
    // Read data
    output qbs_dout_s q_o,
    output logic q_rise_oe_o,
    output logic q_fall_oe_o
);
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1) + 2;
    localparam int PAIR_W = $bits(qbs_pair_s);

    qbs_word_t mem [0:(1 << QBS_ADDR_W) - 1];

    logic [QBS_RD_AGES:1] rd_v_reg, rd_v_next;
    logic [QBS_RD_AGES:1][QBS_ADDR_W-1:0] rd_a_reg, rd_a_next;
    logic [QBS_WR_AGES:1] wr_v_reg, wr_v_next;
    logic [QBS_WR_AGES:1][QBS_ADDR_W-1:0] wr_a_reg, wr_a_next;
    logic idle_reg, idle_next;
    qbs_burst_s [1:0] rec_reg, rec_next;
    qbs_dout_s q_reg, q_next;
    logic q_rise_oe_reg, q_rise_oe_next, q_fall_oe_reg, q_fall_oe_next;

    logic rd_req, wr_req, rd_acc, wr_acc, both_after_idle, wr_room;
    logic [CNT_W-1:0] pend_sum;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    qbs_pair_s push_pair, drain_pair;
    logic [PAIR_W-1:0] drain_raw;
    logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_cnt;
    qbs_word_t commit_w0, commit_w1;

    function automatic qbs_addr_t addr_ofs(input qbs_addr_t base, input int ofs);
        addr_ofs = base + QBS_ADDR_W'(ofs);
    endfunction

    // Lane n covers bits n*9 .. n*9+8; a high enable keeps the old lane
    function automatic qbs_word_t lane_merge(input qbs_word_t old_w, input qbs_word_t new_w,
                                             input qbs_lane_t we_n);
        lane_merge = old_w;
        for (int l = 0; l < QBS_LANES; l++) begin
            if (!we_n[l]) begin
                lane_merge[l*QBS_LANE_W +: QBS_LANE_W] = new_w[l*QBS_LANE_W +: QBS_LANE_W];
            end
        end
    endfunction

    // Array word overlaid by the two newest bursts, newest last
    function automatic qbs_word_t read_word(input qbs_addr_t base, input int ofs);
        qbs_addr_t a;
        qbs_addr_t d;
        a = addr_ofs(base, ofs);
        read_word = mem[a];
        for (int r = 1; r >= 0; r--) begin
            d = a - rec_reg[r].addr;
            if (rec_reg[r].valid && d < QBS_ADDR_W'(QBS_BURST)) begin
                read_word = lane_merge(read_word, rec_reg[r].w[d[1:0]], rec_reg[r].m_n[d[1:0]]);
            end
        end
    endfunction

    // Request acceptance
    always_comb begin
        rd_req = !rd_sel_n_i;
        wr_req = !wr_sel_n_i;
        both_after_idle = idle_reg && rd_req && wr_req;
        pend_sum = CNT_W'(fifo_cnt) + CNT_W'({wr_v_reg[1], 1'b0}) + CNT_W'({wr_v_reg[2], 1'b0})
                 + CNT_W'(wr_v_reg[QBS_AGE_PAIR1]);
        // Cap keeps every uncommitted pair inside the two-burst bypass window
        wr_room = (pend_sum + CNT_W'(QBS_PAIRS_PER_BURST)) <= CNT_W'(PEND_PAIRS);
        rd_acc = rd_req && !rd_v_reg[1];
        wr_acc = wr_req && !wr_v_reg[1] && !both_after_idle && wr_room;
        idle_next = rd_sel_n_i && wr_sel_n_i;
    end

    // Independent read and write age pipelines
    always_comb begin
        rd_v_next = {rd_v_reg[QBS_RD_AGES-1:1], rd_acc};
        rd_a_next = {rd_a_reg[QBS_RD_AGES-1:1], addr_i};
        wr_v_next = {wr_v_reg[QBS_WR_AGES-1:1], wr_acc};
        wr_a_next = {wr_a_reg[QBS_WR_AGES-1:1], addr_i};
    end

    // Read output slots
    always_comb begin
        q_next = q_reg;
        q_rise_oe_next = 1'b0;
        q_fall_oe_next = 1'b0;
        if (rd_v_reg[QBS_AGE_PAIR0]) begin
            q_next.q_fall = read_word(rd_a_reg[QBS_AGE_PAIR0], 0);
            q_fall_oe_next = 1'b1;
        end
        if (rd_v_reg[QBS_AGE_PAIR1]) begin
            q_next.q_rise = read_word(rd_a_reg[QBS_AGE_PAIR1], QBS_OFS_W1);
            q_next.q_fall = read_word(rd_a_reg[QBS_AGE_PAIR1], QBS_OFS_W2);
            q_rise_oe_next = 1'b1;
            q_fall_oe_next = 1'b1;
        end
        if (rd_v_reg[QBS_AGE_LAST]) begin
            q_next.q_rise = read_word(rd_a_reg[QBS_AGE_LAST], QBS_OFS_W3);
            q_rise_oe_next = 1'b1;
        end
    end

    // Write capture into the queue and the bypass bursts
    always_comb begin
        fifo_in_valid = wr_v_reg[QBS_AGE_PAIR0] || wr_v_reg[QBS_AGE_PAIR1];
        push_pair.addr = wr_v_reg[QBS_AGE_PAIR0] ? wr_a_reg[QBS_AGE_PAIR0]
                       : addr_ofs(wr_a_reg[QBS_AGE_PAIR1], QBS_OFS_W2);
        push_pair.w0 = din_i.d_rise;
        push_pair.w1 = din_i.d_fall;
        push_pair.m0_n = din_i.lane_we_rise_n;
        push_pair.m1_n = din_i.lane_we_fall_n;
        rec_next = rec_reg;
        if (wr_v_reg[QBS_AGE_PAIR0]) begin
            rec_next[1] = rec_reg[0];
            rec_next[0].valid = 1'b1;
            rec_next[0].addr = wr_a_reg[QBS_AGE_PAIR0];
            rec_next[0].w = {din_i.d_fall, din_i.d_rise, din_i.d_fall, din_i.d_rise};
            rec_next[0].m_n = {QBS_LANES_OFF, QBS_LANES_OFF, din_i.lane_we_fall_n, din_i.lane_we_rise_n};
        end
        if (wr_v_reg[QBS_AGE_PAIR1]) begin
            rec_next[0].w[QBS_OFS_W2] = din_i.d_rise;
            rec_next[0].w[QBS_OFS_W3] = din_i.d_fall;
            rec_next[0].m_n[QBS_OFS_W2] = din_i.lane_we_rise_n;
            rec_next[0].m_n[QBS_OFS_W3] = din_i.lane_we_fall_n;
        end
    end

    // Commit stalls while a read is fetching from the single array port
    always_comb begin
        drain_pair = qbs_pair_s'(drain_raw);
        fifo_out_ready = !(|rd_v_reg[QBS_RD_AGES:QBS_AGE_PAIR0]);
        commit_w0 = lane_merge(mem[drain_pair.addr], drain_pair.w0, drain_pair.m0_n);
        commit_w1 = lane_merge(mem[addr_ofs(drain_pair.addr, QBS_OFS_W1)], drain_pair.w1, drain_pair.m1_n);
    end

    qbs_fifo #(
        .WIDTH(PAIR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_commit_q (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(PAIR_W'(push_pair)),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(drain_raw),
        .count_o(fifo_cnt)
    );

    // Everything holds while ce_i is low
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_v_reg <= '0;
            rd_a_reg <= '0;
            wr_v_reg <= '0;
            wr_a_reg <= '0;
            idle_reg <= 1'b1;
            rec_reg <= '0;
            q_reg <= '0;
            q_rise_oe_reg <= 1'b0;
            q_fall_oe_reg <= 1'b0;
        end else if (ce_i) begin
            rd_v_reg <= rd_v_next;
            rd_a_reg <= rd_a_next;
            wr_v_reg <= wr_v_next;
            wr_a_reg <= wr_a_next;
            idle_reg <= idle_next;
            rec_reg <= rec_next;
            q_reg <= q_next;
            q_rise_oe_reg <= q_rise_oe_next;
            q_fall_oe_reg <= q_fall_oe_next;
        end
    end

    // Array has no reset; only drained pairs change it
    always_ff @(posedge core_clk_i) begin
        if (!srst_i && ce_i && fifo_out_valid && fifo_out_ready) begin
            mem[drain_pair.addr] <= commit_w0;
            mem[addr_ofs(drain_pair.addr, QBS_OFS_W1)] <= commit_w1;
        end
    end

    assign q_o = q_reg;
    assign q_rise_oe_o = q_rise_oe_reg;
    assign q_fall_oe_o = q_fall_oe_reg;

    // Rise slot of the first pair is busy only when a read two edges earlier ends there
    chk_rd_slot_order: assert property (@(posedge core_clk_i) disable iff (srst_i || !ce_i)
        rd_acc |-> ##3 (q_fall_oe_o && (q_rise_oe_o == $past(rd_v_reg[QBS_AGE_LAST])))
        ##1 (q_rise_oe_o && q_fall_oe_o) ##1 q_rise_oe_o)
        else $error("read burst slots out of place");
    chk_rd_word0_data: assert property (@(posedge core_clk_i) disable iff (srst_i || !ce_i)
        rd_v_reg[QBS_AGE_PAIR0] |-> (rd_a_reg[QBS_AGE_PAIR0] == $past(addr_i, 2)))
        else $error("first read word not from base address");
    chk_rd_back_drop: assert property (@(posedge core_clk_i) disable iff (srst_i || !ce_i)
        rd_acc |=> !rd_acc) else $error("second back-to-back read taken");
    chk_wr_back_drop: assert property (@(posedge core_clk_i) disable iff (srst_i || !ce_i)
        wr_acc |=> !wr_acc) else $error("second back-to-back write taken");
    chk_rd_wins_idle: assert property (@(posedge core_clk_i) disable iff (srst_i || !ce_i)
        (idle_reg && !rd_sel_n_i && !wr_sel_n_i) |-> (rd_acc && !wr_acc))
        else $error("write not dropped after idle cycle");
    chk_rd_take: assert property (@(posedge core_clk_i) disable iff (srst_i || !ce_i)
        (!rd_sel_n_i && !rd_v_reg[1]) |-> rd_acc) else $error("valid read request lost");
    chk_wr_needs_sel: assert property (@(posedge core_clk_i) disable iff (srst_i || !ce_i)
        wr_acc |-> !wr_sel_n_i) else $error("write taken without select");
    chk_idle_release: assert property (@(posedge core_clk_i) disable iff (srst_i || !ce_i)
        (rd_v_reg == '0 && rd_sel_n_i) |=> ##1 (!q_fall_oe_o && !q_rise_oe_o))
        else $error("outputs driven with no read pending");
    chk_wr_push_pair: assert property (@(posedge core_clk_i) disable iff (srst_i || !ce_i)
        wr_acc |-> ##2 (fifo_in_valid && fifo_in_ready) ##1 (fifo_in_valid && fifo_in_ready))
        else $error("write pairs not queued at t+2 and t+3");
    chk_freeze_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !ce_i |=> ($stable(q_o) && $stable(q_rise_oe_o) && $stable(q_fall_oe_o)))
        else $error("outputs moved while clock enable low");
    cov_concurrent: cover property (@(posedge core_clk_i) disable iff (srst_i) rd_acc ##1 wr_acc);
    cov_read: cover property (@(posedge core_clk_i) disable iff (srst_i) rd_acc ##2 rd_acc);
    cov_commit_stall: cover property (@(posedge core_clk_i) disable iff (srst_i)
        fifo_out_valid && !fifo_out_ready);
    cov_wr_refused: cover property (@(posedge core_clk_i) disable iff (srst_i)
        !wr_sel_n_i && !wr_v_reg[1] && !both_after_idle && !wr_room);
endmodule
`default_nettype wire

// *** hdl/qbs_pkg.sv ***
/*
 Shared constants and carriers of the burst-of-four SRAM protocol core.
 Assumes one core clock; each core cycle carries one rise-phase and one fall-phase word.
*/
`default_nettype none
package qbs_pkg;
    localparam int QBS_DATA_W = 18;
    localparam int QBS_LANE_W = 9;
    localparam int QBS_LANES = 2;
    localparam int QBS_ADDR_W = 21;
    localparam int QBS_BURST = 4;
    localparam int QBS_PAIRS_PER_BURST = 2;
    localparam int QBS_FIFO_DEPTH = 8;
    // Pending pairs kept at most two bursts deep so the bypass stays coherent
    localparam int QBS_PEND_PAIRS = 4;
    // Ages of a request, in rising edges after the one that took it
    localparam int QBS_RD_AGES = 4;
    localparam int QBS_WR_AGES = 3;
    localparam int QBS_AGE_PAIR0 = 2;
    localparam int QBS_AGE_PAIR1 = 3;
    localparam int QBS_AGE_LAST = 4;
    // Word offsets inside a burst
    localparam int QBS_OFS_W1 = 1;
    localparam int QBS_OFS_W2 = 2;
    localparam int QBS_OFS_W3 = 3;

    typedef logic [QBS_DATA_W-1:0] qbs_word_t;
    typedef logic [QBS_LANES-1:0] qbs_lane_t;
    typedef logic [QBS_ADDR_W-1:0] qbs_addr_t;

    localparam qbs_lane_t QBS_LANES_OFF = 2'h3;

    typedef struct packed {
        qbs_word_t d_rise;
        qbs_word_t d_fall;
        qbs_lane_t lane_we_rise_n;
        qbs_lane_t lane_we_fall_n;
    } qbs_din_s;

    typedef struct packed {
        qbs_word_t q_rise;
        qbs_word_t q_fall;
    } qbs_dout_s;

    typedef struct packed {
        qbs_addr_t addr;
        qbs_word_t w0;
        qbs_word_t w1;
        qbs_lane_t m0_n;
        qbs_lane_t m1_n;
    } qbs_pair_s;

    typedef struct packed {
        logic valid;
        qbs_addr_t addr;
        logic [QBS_BURST-1:0][QBS_DATA_W-1:0] w;
        logic [QBS_BURST-1:0][QBS_LANES-1:0] m_n;
    } qbs_burst_s;
endpackage
`default_nettype wire

// *** hdl/qbs_fifo.sv ***
/*
 Write-commit queue of word pairs, parameterised in width and depth.
 Assumes the filler honours in_ready_o and the drainer may stall at will.
*/
`timescale 1ns/100ps
`default_nettype none
module qbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and control
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic push, pop;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_W'(1);
    endfunction

    assign in_ready_o = (cnt_reg != CNT_FULL);
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign count_o = cnt_reg;

    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wr_ptr_next = push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
        rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
        cnt_next = cnt_reg + CNT_W'(push) - CNT_W'(pop);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else if (ce_i) begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg <= cnt_next;
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data_i;
            end
        end
    end

    chk_no_overflow: assert property (@(posedge core_clk_i) disable iff (srst_i)
        cnt_reg <= CNT_FULL) else $error("fifo count above depth");
endmodule
`default_nettype wire

// *** sim/qbs_host_model.sv ***
/*
 Host-side model: drives selects, address and the write data of each burst.
 Assumes the bench calls issue() one cycle at a time and ce_i is the core enable.
*/
`timescale 1ns/100ps
`default_nettype none
module qbs_host_model import qbs_pkg::*; (
    // Clock and enable
    input wire logic core_clk_i,
    input wire logic ce_i,
    // Command and data
    output logic rd_sel_n_o,
    output logic wr_sel_n_o,
    output qbs_addr_t addr_o,
    output qbs_din_s din_o
);
    logic req_rd = 1'b0;
    logic req_wr = 1'b0;
    qbs_addr_t req_a = '0;
    qbs_burst_s req_b = '0;
    qbs_burst_s cur_b = '0;
    qbs_burst_s s1 = '0;
    qbs_burst_s s2 = '0;
    qbs_burst_s s3 = '0;
    initial begin
        rd_sel_n_o = 1'b1;
        wr_sel_n_o = 1'b1;
        addr_o = '0;
        din_o = '0;
    end
    task automatic issue(input logic rd, input logic wr, input qbs_addr_t a, input qbs_burst_s b);
        req_rd = rd;
        req_wr = wr;
        req_a = a;
        req_b = b;
        @(negedge core_clk_i);
        #1;
        req_rd = 1'b0;
        req_wr = 1'b0;
    endtask
    always @(negedge core_clk_i) begin
        rd_sel_n_o <= !req_rd;
        wr_sel_n_o <= !req_wr;
        // Unused lines toggle so a stale value is never mistaken for data
        addr_o <= (req_rd || req_wr) ? req_a : ~addr_o;
        cur_b <= req_b;
        if (s3.valid) begin
            din_o <= {s3.w[2], s3.w[3], s3.m_n[2], s3.m_n[3]};
        end else if (s2.valid) begin
            din_o <= {s2.w[0], s2.w[1], s2.m_n[0], s2.m_n[1]};
        end else begin
            din_o <= ~din_o;
        end
    end
    // Stopped clock: the host stalls its own pipeline too
    always @(posedge core_clk_i) if (ce_i) begin
        s1 <= '0;
        if (!wr_sel_n_o) begin
            s1 <= cur_b;
            s1.valid <= 1'b1;
        end
        s2 <= s1;
        s3 <= s2;
    end
endmodule
`default_nettype wire

// *** sim/quad_port_burst4_sram_protocol_bench.sv ***
/*
 Self-checking bench of the burst-of-four protocol core.
 Assumes the host model drives the command side; a shadow memory predicts reads.
*/
`timescale 1ns/100ps
`default_nettype none
module quad_port_burst4_sram_protocol_bench import qbs_pkg::*; ();
    typedef struct packed {logic r_oe; logic f_oe; qbs_word_t r; qbs_word_t f;} qbs_slot_s;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic rd_sel_n, wr_sel_n, rise_oe, fall_oe;
    qbs_addr_t addr;
    qbs_din_s din;
    qbs_dout_s q, q_save;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    qbs_word_t mem [qbs_addr_t];
    qbs_slot_s slot [16];
    int unsigned pos = 0;
    logic prev_rd = 1'b0, prev_wr = 1'b0, prev_idle = 1'b1;
    qbs_burst_s rows [5] = '{
        '{1'b1, 21'h000010, {18'h3C3C3, 18'h2B2B2, 18'h1A1A1, 18'h0F0F0}, 8'h00},
        '{1'b1, 21'h000010, {18'h15555, 18'h2AAAA, 18'h3FFFF, 18'h12345}, 8'hE4},
        '{1'b1, 21'h1FFFFE, {18'h00C0D, 18'h00A0B, 18'h00809, 18'h00607}, 8'h00},
        '{1'b1, 21'h000100, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, 8'h00},
        '{1'b1, 21'h000100, {18'h0ABCD, 18'h1BCDE, 18'h2CDEF, 18'h3DEF0}, 8'h1B}};
    always #10 core_clk_i = ~core_clk_i;
    qbs_core uut (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .rd_sel_n_i(rd_sel_n),
        .wr_sel_n_i(wr_sel_n), .addr_i(addr), .din_i(din), .q_o(q), .q_rise_oe_o(rise_oe),
        .q_fall_oe_o(fall_oe));
    qbs_host_model host (.core_clk_i(core_clk_i), .ce_i(ce_i), .rd_sel_n_o(rd_sel_n),
        .wr_sel_n_o(wr_sel_n), .addr_o(addr), .din_o(din));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Mismatches %0d, comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk_i);
        #1;
    endtask
    function automatic void put(input int unsigned p, input logic rise, input qbs_word_t v);
        if (rise) begin
            slot[p % 16].r_oe = 1'b1;
            slot[p % 16].r = v;
        end else begin
            slot[p % 16].f_oe = 1'b1;
            slot[p % 16].f = v;
        end
    endfunction
    // Timeout in a process of its own so nothing runs after the verdict
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles > 1500) begin
            err_count++;
            complete_run();
        end
    end
    // Reference sequencers, advanced only on enabled edges
    always @(posedge core_clk_i) begin : ref_model
        logic rt, wt;
        qbs_addr_t a;
        a = addr;
        if (srst_i) begin
            prev_rd = 1'b0;
            prev_wr = 1'b0;
            prev_idle = 1'b1;
            slot = '{default: '0};
        end else if (ce_i) begin
            rt = !rd_sel_n && !prev_rd;
            wt = !wr_sel_n && !prev_wr && !(!rd_sel_n && prev_idle);
            slot[pos % 16] = '0;
            pos++;
            // Snapshot before the write so a same-edge read sees older data
            if (rt) for (int i = 0; i < 4; i++) put(pos + 2 + (i + 1) / 2, i[0], mem[qbs_addr_t'(a + i)]);
            if (wt) for (int i = 0; i < 4; i++) for (int l = 0; l < QBS_LANES; l++)
                if (!host.cur_b.m_n[i][l]) mem[qbs_addr_t'(a + i)][l*QBS_LANE_W +: QBS_LANE_W] =
                    host.cur_b.w[i][l*QBS_LANE_W +: QBS_LANE_W];
            prev_rd = rt;
            prev_wr = wt;
            prev_idle = rd_sel_n && wr_sel_n;
        end
    end
    always @(negedge core_clk_i) if (!srst_i) begin
        check(fall_oe, slot[pos % 16].f_oe);
        check(rise_oe, slot[pos % 16].r_oe);
        if (slot[pos % 16].f_oe) check(q.q_fall, slot[pos % 16].f);
        if (slot[pos % 16].r_oe) check(q.q_rise, slot[pos % 16].r);
    end
    initial begin
        idle(10);
        srst_i = 1'b0;
        check({rise_oe, fall_oe, q}, '0);
        foreach (rows[k]) begin
            host.issue(1'b0, 1'b1, rows[k].addr, rows[k]);
            idle(3);
            host.issue(1'b1, 1'b0, rows[k].addr, '0);
            idle(5);
        end
        // Read at t, write at t+1, alternating
        host.issue(1'b1, 1'b0, 21'h000010, '0);
        host.issue(1'b0, 1'b1, 21'h000200, rows[0]);
        host.issue(1'b1, 1'b0, 21'h1FFFFE, '0);
        host.issue(1'b0, 1'b1, 21'h000204, rows[3]);
        idle(3);
        host.issue(1'b1, 1'b0, 21'h000200, '0);
        idle(1);
        host.issue(1'b1, 1'b0, 21'h000204, '0);
        idle(6);
        // Back-to-back reads, then back-to-back writes
        host.issue(1'b1, 1'b0, 21'h000010, '0);
        host.issue(1'b1, 1'b0, 21'h000100, '0);
        idle(6);
        host.issue(1'b0, 1'b1, 21'h000010, rows[3]);
        host.issue(1'b0, 1'b1, 21'h000100, rows[0]);
        idle(3);
        host.issue(1'b1, 1'b0, 21'h000010, '0);
        idle(1);
        host.issue(1'b1, 1'b0, 21'h000100, '0);
        idle(6);
        // Both selects low after idle
        host.issue(1'b1, 1'b1, 21'h000100, rows[2]);
        idle(4);
        host.issue(1'b1, 1'b0, 21'h000100, '0);
        idle(6);
        // Both selects low every edge: reads and writes alternate, and writes fill the queue up to the cap
        for (int k = 0; k < 10; k++)
            host.issue(1'b1, 1'b1, k[0] ? 21'h000300 + 21'(4 * k) : (k[1] ? 21'h000010 : 21'h1FFFFE), rows[k % 5]);
        idle(8);
        // Clock halted only once every burst is done
        host.issue(1'b1, 1'b0, 21'h000010, '0);
        idle(6);
        q_save = q;
        ce_i = 1'b0;
        idle(3);
        check(q, q_save);
        ce_i = 1'b1;
        idle(2);
        // Reset in mid-burst releases the outputs
        host.issue(1'b1, 1'b0, 21'h000010, '0);
        idle(2);
        srst_i = 1'b1;
        idle(2);
        srst_i = 1'b0;
        idle(1);
        check({rise_oe, fall_oe}, 2'h0);
        host.issue(1'b1, 1'b1, 21'h000100, rows[1]);
        idle(6);
        complete_run();
    end
endmodule
`default_nettype wire
